/* dv/splc_core_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// core side: ram write capture and trap intake
// ****************************************************************
module splc_core_model
  import splc_pkg::*;
(
  input  wire logic      clk,      // core clock
  input  wire logic      rst_n,    // sync reset, active low
  input  wire splc_mem_s mem,      // ram access from block
  input  wire logic      trap,     // trap request
  output logic [15:0]    wr_word,  // last word written
  output logic [7:0]     trap_cnt  // traps taken
);
  // store each pushed word as the ram would
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_word <= 16'h0000;
    end else if (mem.wr) begin
      wr_word <= mem.wdata;
    end
  end
  // exception logic takes one trap per cycle that trap is high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trap_cnt <= 8'h00;
    end else if (trap) begin
      trap_cnt <= trap_cnt + 8'h01;
    end
  end
endmodule // splc_core_model

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import splc_pkg::*;
  logic        clk, rst_n, lim_we, sp_we, flag_clr, trap;
  logic        err_over, err_under;
  logic [6:0]  status_low_byte;
  logic [15:0] lim_wdata, sp_wdata, stack_pointer, stack_limit, wr_word;
  logic [7:0]  trap_cnt;
  splc_req_s   req;
  splc_mem_s   mem;
  int          errors, n_checks;
  // ****************************************************************
  // design and core model
  // ****************************************************************
  splc_stack_limit uut (.clk(clk), .rst_n(rst_n), .req(req),
    .status_low_byte(status_low_byte), .lim_we(lim_we),
    .lim_wdata(lim_wdata), .sp_we(sp_we), .sp_wdata(sp_wdata),
    .flag_clr(flag_clr), .mem(mem), .stack_pointer(stack_pointer),
    .stack_limit(stack_limit), .trap(trap), .err_over(err_over),
    .err_under(err_under));
  splc_core_model core (.clk(clk), .rst_n(rst_n), .mem(mem), .trap(trap),
    .wr_word(wr_word), .trap_cnt(trap_cnt));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [16:0] got, exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic step();  // one edge, then let it settle
    @(posedge clk);
    #2;
  endtask
  task automatic issue(input splc_op_e o, input logic [15:0] d, a);
    req = '{op: o, data: d, effective_addr: a};
    step();
  endtask
  task automatic idle();
    req = '{op: SPLC_OP_NONE, data: 16'h0000, effective_addr: 16'h0000};
    step();
  endtask
  task automatic wr_lim(input logic [15:0] v);
    lim_we = 1'b1;
    lim_wdata = v;
    step();
    lim_we = 1'b0;
  endtask
  task automatic set_sp(input logic [15:0] v);
    sp_we = 1'b1;
    sp_wdata = v;
    step();
    sp_we = 1'b0;
  endtask
  task automatic clr();
    flag_clr = 1'b1;
    step();
    flag_clr = 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_push_pop();
    wr_lim(16'h0807);
    chk(stack_limit, 16'h0806, "limit bit0");
    issue(SPLC_OP_PUSH, 16'hA5A5, 16'h0000);
    chk({mem.wr, mem.addr}, 17'h1_0800, "push1 addr");
    chk(stack_pointer, 16'h0802, "push1 sp");
    issue(SPLC_OP_PUSH, 16'h5A5A, 16'h0000);
    chk(mem.addr, 16'h0802, "push2 addr");
    issue(SPLC_OP_POP, 16'h0000, 16'h0000);
    chk({mem.rd, mem.addr}, 17'h1_0802, "pop addr");
    chk(stack_pointer, 16'h0802, "pop sp");
    chk(wr_word, 16'h5A5A, "ram word");
    idle();
    $display("test push_pop done");
  endtask
  task automatic t_pc_push();
    status_low_byte = 7'h55;
    issue(SPLC_OP_CALL, 16'hFFFF, 16'h0000);
    chk(mem.wdata, 16'h7FFF, "call msb");
    issue(SPLC_OP_EXC, 16'hFFFF, 16'h0000);
    chk(mem.wdata, 16'hABFF, "exc word");
    idle();
    $display("test pc_push done");
  endtask
  task automatic t_limit();
    wr_lim(16'h0806);
    set_sp(16'h0804);  // next cycle after limit write, no idle gap
    issue(SPLC_OP_PUSH, 16'h1111, 16'h0000);
    chk(trap, 1'b0, "below limit");
    issue(SPLC_OP_PUSH, 16'h2222, 16'h0000);
    chk({trap, mem.addr}, 17'h0_0806, "at limit");
    issue(SPLC_OP_PUSH, 16'h3333, 16'h0000);
    chk({trap, err_over}, 2'b11, "past limit");
    idle();
    chk({trap, err_over}, 2'b01, "pulse sticky");
    clr();
    chk(err_over, 1'b0, "flag clear");
    $display("test limit done");
  endtask
  task automatic t_under_addr();
    set_sp(16'h07FE);
    issue(SPLC_OP_PUSH, 16'h4444, 16'h0000);
    chk({trap, err_under, err_over}, 3'b110, "underflow");
    issue(SPLC_OP_ADDR, 16'h0000, 16'h0900);
    chk({trap, err_over}, 2'b11, "addr over");
    chk(stack_pointer, 16'h0800, "addr keeps sp");
    issue(SPLC_OP_ADDR, 16'h0000, 16'h0805);
    chk(trap, 1'b0, "addr inside");
    idle();
    clr();
    chk({err_over, err_under}, 2'b00, "flags clear");
    chk(trap_cnt, 8'h03, "trap count");
    $display("test under_addr done");
  endtask
  // mid-run reset keeps the limit; direct write beats a push
  task automatic t_reset();
    issue(SPLC_OP_PUSH, 16'h7777, 16'h0000);
    chk(stack_pointer, 16'h0802, "pre reset sp");
    rst_n = 1'b0;
    idle();
    rst_n = 1'b1;
    chk({trap, err_over, err_under, mem.wr}, 4'h0, "mid reset outs");
    chk(stack_pointer, 16'h0800, "mid reset sp");
    chk(stack_limit, 16'h0806, "limit kept");
    sp_we = 1'b1;
    sp_wdata = 16'h0A00;
    issue(SPLC_OP_PUSH, 16'h6666, 16'h0000);
    sp_we = 1'b0;
    chk({mem.wr, mem.addr}, 17'h1_0800, "push beside write");
    chk(stack_pointer, 16'h0A00, "write beats push");
    chk(trap, 1'b0, "no trap at base");
    idle();
    $display("test reset done");
  endtask
  // ****************************************************************
  // clock, watchdog, main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    stop_test();
  end
  initial begin
    errors = 0;
    n_checks = 0;
    rst_n = 1'b0;
    req = '{op: SPLC_OP_NONE, data: 16'h0000, effective_addr: 16'h0000};
    {lim_we, sp_we, flag_clr} = 3'b000;
    {lim_wdata, sp_wdata} = 32'h0000_0000;
    status_low_byte = 7'h00;
    repeat (6) @(posedge clk);
    #2;
    rst_n = 1'b1;
    chk(stack_pointer, 16'h0800, "reset sp");
    chk({trap, err_over, err_under, mem.wr}, 4'h0, "reset outs");
    t_push_pop();
    t_pc_push();
    t_limit();
    t_under_addr();
    t_reset();
    stop_test();
  end
endmodule // testbench

/* hdl/splc_limit_cmp.sv */
`timescale 1ns/1ps
// ****************************************************************
// limit comparator: flags overflow and underflow of one address
// ****************************************************************
module splc_limit_cmp
  import splc_pkg::*;
(
  input  wire logic [15:0] addr,      // effective address
  input  wire logic [15:0] limit,     // stack limit
  input  wire logic        check,     // address formed via pointer
  output logic             over,      // beyond limit
  output logic             under      // below ram bottom
);

  // compare combinationally
  always_comb begin
    over  = check && (addr > limit);
    under = check && (addr < SPLC_UNDERFLOW);
  end

endmodule // splc_limit_cmp

/* hdl/splc_pkg.sv */
package splc_pkg;

  // ****************************************************************
  // widths and constants
  // ****************************************************************
  localparam int          SPLC_AW        = 16;          // address width
  localparam logic [15:0] SPLC_UNDERFLOW = 16'h0800;    // lowest stack addr
  localparam logic [15:0] SPLC_SP_RST    = 16'h0800;    // pointer at reset
  localparam logic [15:0] SPLC_WORD      = 16'h0002;    // one stack word
  localparam logic [15:0] SPLC_ALIGN     = 16'hFFFE;    // word align mask
  localparam logic [15:0] SPLC_ZERO      = 16'h0000;    // cleared word

  // stack operation requested by the core
  typedef enum logic [2:0] {
    SPLC_OP_NONE = 3'b000,   // idle
    SPLC_OP_PUSH = 3'b001,   // plain data push
    SPLC_OP_POP  = 3'b010,   // plain data pop
    SPLC_OP_CALL = 3'b011,   // call program counter push
    SPLC_OP_EXC  = 3'b100,   // exception program counter push
    SPLC_OP_ADDR = 3'b101    // other access through the pointer
  } splc_op_e;

  // request from core address generation
  typedef struct packed {
    splc_op_e    op;         // operation
    logic [15:0] data;       // push data or pc word
    logic [15:0] effective_addr; // address for SPLC_OP_ADDR
  } splc_req_s;

  // memory access towards data ram
  typedef struct packed {
    logic        wr;         // write strobe
    logic        rd;         // read strobe
    logic [15:0] addr;       // word address
    logic [15:0] wdata;      // write data
  } splc_mem_s;

endpackage

/* hdl/splc_stack_limit.sv */
`timescale 1ns/1ps
// Operation
// - pointer holds first free word, grows upward
// - push writes then increments; pop decrements first
// - call push clears pc msb
// - exception push places 7 status bits on top
// - limit register not cleared by reset
// - limit bit zero reads zero after any limit write
// - every pointer address compared with limit
// - push at limit fine, next one traps
// - address below 0x0800 raises underflow trap
module splc_stack_limit
  import splc_pkg::*;
(
  input  wire logic        clk,           // core clock
  input  wire logic        rst_n,         // sync reset, active low
  input  wire splc_req_s   req,           // stack request
  input  wire logic [6:0]  status_low_byte, // status low bits
  input  wire logic        lim_we,        // limit write strobe
  input  wire logic [15:0] lim_wdata,     // limit write data
  input  wire logic        sp_we,         // direct pointer write
  input  wire logic [15:0] sp_wdata,      // direct pointer data
  input  wire logic        flag_clr,      // clear sticky flag
  output splc_mem_s        mem,           // ram access
  output logic [15:0]      stack_pointer, // pointer value
  output logic [15:0]      stack_limit,   // limit readback
  output logic             trap,          // one-cycle trap request
  output logic             err_over,      // sticky overflow flag
  output logic             err_under      // sticky underflow flag
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [15:0] stack_pointer_reg;  // pointer
  logic [15:0] stack_pointer_next; // pointer next
  logic [15:0] limit_reg;          // limit, no reset
  splc_mem_s   mem_reg;            // registered ram access
  splc_mem_s   mem_next;           // ram access next
  logic        trap_reg;           // trap pulse
  logic        over_reg;           // sticky overflow
  logic        under_reg;          // sticky underflow
  logic [15:0] effective_addr;     // address checked
  logic        check;              // check enable
  logic        hit_over;           // overflow this cycle
  logic        hit_under;          // underflow this cycle

  // align a word address
  function automatic logic [15:0] align(input logic [15:0] a);
    align = a & SPLC_ALIGN;
  endfunction

  // ****************************************************************
  // pointer and memory access decode
  // ****************************************************************
  always_comb begin
    stack_pointer_next = stack_pointer_reg;
    mem_next           = '{wr: 1'b0, rd: 1'b0, addr: SPLC_ZERO,
                           wdata: SPLC_ZERO};
    effective_addr     = stack_pointer_reg;
    check              = 1'b0;
    case (req.op)
      SPLC_OP_PUSH: begin  // write then increment
        mem_next = '{wr: 1'b1, rd: 1'b0, addr: stack_pointer_reg,
                     wdata: req.data};
        stack_pointer_next = stack_pointer_reg + SPLC_WORD;
        check = 1'b1;
      end
      SPLC_OP_CALL: begin  // msb forced low
        mem_next = '{wr: 1'b1, rd: 1'b0, addr: stack_pointer_reg,
                     wdata: {1'b0, req.data[14:0]}};
        stack_pointer_next = stack_pointer_reg + SPLC_WORD;
        check = 1'b1;
      end
      SPLC_OP_EXC: begin   // 7 status bits joined on top
        mem_next = '{wr: 1'b1, rd: 1'b0, addr: stack_pointer_reg,
                     wdata: {status_low_byte, req.data[8:0]}};
        stack_pointer_next = stack_pointer_reg + SPLC_WORD;
        check = 1'b1;
      end
      SPLC_OP_POP: begin   // decrement then read
        stack_pointer_next = stack_pointer_reg - SPLC_WORD;
        mem_next = '{wr: 1'b0, rd: 1'b1, addr: stack_pointer_next,
                     wdata: SPLC_ZERO};
        effective_addr = stack_pointer_next;
        check = 1'b1;
      end
      SPLC_OP_ADDR: begin  // other pointer use
        effective_addr = align(req.effective_addr);
        check = 1'b1;
      end
      default: begin       // idle
        check = 1'b0;
      end
    endcase
  end

  // limit compare
  splc_limit_cmp u_cmp (
    .addr  (effective_addr),
    .limit (limit_reg),
    .check (check),
    .over  (hit_over),
    .under (hit_under)
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  // pointer, direct write has priority over stack ops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stack_pointer_reg <= SPLC_SP_RST;
    end else if (sp_we) begin
      stack_pointer_reg <= align(sp_wdata);
    end else begin
      stack_pointer_reg <= stack_pointer_next;
    end
  end

  // limit: no reset, bit zero held low
  always_ff @(posedge clk) begin
    if (lim_we) begin
      limit_reg <= align(lim_wdata);
    end
  end

  // ram access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_reg <= '{wr: 1'b0, rd: 1'b0, addr: SPLC_ZERO, wdata: SPLC_ZERO};
    end else begin
      mem_reg <= mem_next;
    end
  end

  // trap pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trap_reg <= 1'b0;
    end else begin
      trap_reg <= hit_over | hit_under;
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      over_reg  <= 1'b0;
      under_reg <= 1'b0;
    end else begin
      over_reg  <= hit_over  | (over_reg  & ~flag_clr);
      under_reg <= hit_under | (under_reg & ~flag_clr);
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign mem           = mem_reg;
  assign stack_pointer = stack_pointer_reg;
  assign stack_limit   = limit_reg;
  assign trap          = trap_reg;
  assign err_over      = over_reg;
  assign err_under     = under_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_push_inc;
    @(posedge clk) disable iff (!rst_n)
      (req.op == SPLC_OP_PUSH && !sp_we) |=>
        stack_pointer == $past(stack_pointer) + SPLC_WORD;
  endproperty
  a_push_inc: assert property (p_push_inc)
    else $error("push did not advance pointer");

  property p_push_addr;
    @(posedge clk) disable iff (!rst_n)
      req.op == SPLC_OP_PUSH |=>
        mem.wr && mem.addr == $past(stack_pointer);
  endproperty
  a_push_addr: assert property (p_push_addr)
    else $error("push wrote wrong address");

  property p_pop_addr;
    @(posedge clk) disable iff (!rst_n)
      req.op == SPLC_OP_POP |=>
        mem.rd && mem.addr == $past(stack_pointer) - SPLC_WORD;
  endproperty
  a_pop_addr: assert property (p_pop_addr)
    else $error("pop read wrong address");

  property p_call_msb;
    @(posedge clk) disable iff (!rst_n)
      req.op == SPLC_OP_CALL |=> mem.wr && !mem.wdata[15];
  endproperty
  a_call_msb: assert property (p_call_msb)
    else $error("call push msb set");

  property p_exc_status;
    @(posedge clk) disable iff (!rst_n)
      req.op == SPLC_OP_EXC |=>
        mem.wdata[15:9] == $past(status_low_byte);
  endproperty
  a_exc_status: assert property (p_exc_status)
    else $error("exception push lost status");

  property p_lim_bit0;
    @(posedge clk) disable iff (!rst_n)
      lim_we |=> stack_limit == {$past(lim_wdata[15:1]), 1'b0};
  endproperty
  a_lim_bit0: assert property (p_lim_bit0)
    else $error("limit bit zero set");

  property p_at_limit;
    @(posedge clk) disable iff (!rst_n)
      (req.op == SPLC_OP_PUSH && stack_pointer == stack_limit &&
       stack_pointer >= SPLC_UNDERFLOW) |=> !trap;
  endproperty
  a_at_limit: assert property (p_at_limit)
    else $error("trap on push at limit");

  property p_over_trap;
    @(posedge clk) disable iff (!rst_n)
      (req.op == SPLC_OP_PUSH && stack_pointer > stack_limit) |=>
        trap && err_over;
  endproperty
  a_over_trap: assert property (p_over_trap)
    else $error("missing overflow trap");

  property p_under_trap;
    @(posedge clk) disable iff (!rst_n)
      (req.op == SPLC_OP_PUSH && stack_pointer < SPLC_UNDERFLOW) |=>
        trap && err_under;
  endproperty
  a_under_trap: assert property (p_under_trap)
    else $error("missing underflow trap");

  property p_sticky;
    @(posedge clk) disable iff (!rst_n)
      (err_over && !flag_clr) |=> err_over;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("overflow flag dropped");

endmodule // splc_stack_limit
